// ===== cis_pkg.sv
package cis_pkg;

	typedef logic [14:0] cis_pc_t;
	typedef logic [13:0] cis_op_t;
	typedef logic [15:0] cis_ptr_t;

	// Widths and depths
	localparam int STACK_DEPTH = 16;
	localparam int SP_W        = 4;

	// Values after reset
	localparam cis_pc_t    PC_RESET    = 15'h0000;
	localparam logic [7:0] W_RESET     = 8'h00;
	localparam cis_ptr_t   PTR_RESET   = 16'h0000;
	localparam logic [3:0] SP_RESET    = 4'h0;
	localparam logic       FLAG_RESET  = 1'b0;
	localparam logic       TO_RESET    = 1'b1;
	localparam logic       PD_RESET    = 1'b1;

	// File addresses of the two indirect windows
	localparam logic [6:0] WINDOW0_ADDR = 7'h00;
	localparam logic [6:0] WINDOW1_ADDR = 7'h01;

	// Instruction field positions
	localparam int F_MSB    = 6;
	localparam int DEST_BIT = 7;
	localparam int BIT_LSB  = 7;
	localparam int BIT_MSB  = 9;
	localparam int LIT8_MSB = 7;
	localparam int BRA_MSB  = 8;
	localparam int JMP_MSB  = 10;
	localparam int SEL_STEP = 2;
	localparam int SEL_IDX  = 6;
	localparam int OFS_MSB  = 5;

	// Opcode masks and values
	localparam cis_op_t M_BYTE   = 14'h3F00;
	localparam cis_op_t V_INV    = 14'h0900;
	localparam cis_op_t V_DEC    = 14'h0300;
	localparam cis_op_t V_DECSZ  = 14'h0B00;
	localparam cis_op_t V_INC    = 14'h0A00;
	localparam cis_op_t V_INCSZ  = 14'h0F00;
	localparam cis_op_t V_ORF    = 14'h0400;
	localparam cis_op_t V_COPY   = 14'h0800;
	localparam cis_op_t V_SHL    = 14'h3500;
	localparam cis_op_t V_SHR    = 14'h3600;
	localparam cis_op_t V_ORL    = 14'h3800;
	localparam cis_op_t M_REGISTER_ZEROING   = 14'h3F80;
	localparam cis_op_t V_REGISTER_ZEROING   = 14'h0180;
	localparam cis_op_t M_ACCUMULATOR_ZEROING   = 14'h3FFC;
	localparam cis_op_t V_ACCUMULATOR_ZEROING   = 14'h0100;
	localparam cis_op_t M_BIT    = 14'h3C00;
	localparam cis_op_t V_BSET   = 14'h1400;
	localparam cis_op_t V_BTST   = 14'h1C00;
	localparam cis_op_t M_BRA    = 14'h3E00;
	localparam cis_op_t V_BRA    = 14'h3200;
	localparam cis_op_t M_JMP    = 14'h3800;
	localparam cis_op_t V_CALL   = 14'h2000;
	localparam cis_op_t V_ABSOLUTE_JUMP   = 14'h2800;
	localparam cis_op_t M_EXACT  = 14'h3FFF;
	localparam cis_op_t V_BRW    = 14'h000B;
	localparam cis_op_t V_ACCUMULATOR_SUBROUTINE_ENTER  = 14'h000A;
	localparam cis_op_t V_KICK   = 14'h0064;
	localparam cis_op_t M_ILDS   = 14'h3FF8;
	localparam cis_op_t V_ILDS   = 14'h0010;
	localparam cis_op_t M_ILDX   = 14'h3F80;
	localparam cis_op_t V_ILDX   = 14'h3F00;

	// Pointer step kinds
	localparam logic [1:0] STEP_PRE_INC  = 2'b00;
	localparam logic [1:0] STEP_PRE_DEC  = 2'b01;
	localparam logic [1:0] STEP_POST_INC = 2'b10;
	localparam logic [1:0] STEP_POST_DEC = 2'b11;

	typedef enum logic [3:0] {
		ALU_PASS,
		ALU_INV,
		ALU_DEC,
		ALU_INC,
		ALU_OR,
		ALU_SHL,
		ALU_SHR,
		ALU_ZERO,
		ALU_BSET
	} cis_alu_e;

	function automatic logic is_op(input cis_op_t op, input cis_op_t mask, input cis_op_t val);
		return (op & mask) == val;
	endfunction

endpackage

// ===== cis_if.sv
`timescale 1ns/1ns
interface cis_alu_if;
	import cis_pkg::*;
	cis_alu_e   op;
	logic [7:0] a;
	logic [7:0] b;
	logic [2:0] bsel;
	logic [7:0] res;
	logic       cout;
	logic       zero;
	logic       bit_val;
	modport core (output op, a, b, bsel, input res, cout, zero, bit_val);
	modport alu  (input op, a, b, bsel, output res, cout, zero, bit_val);
endinterface

interface cis_ptr_if;
	import cis_pkg::*;
	logic       sel;
	logic       indexed;
	logic       commit;
	logic [1:0] kind;
	logic [5:0] offset;
	cis_ptr_t   ea;
	cis_ptr_t   ptr0;
	cis_ptr_t   ptr1;
	modport core (output sel, indexed, commit, kind, offset, input ea, ptr0, ptr1);
	modport unit (input sel, indexed, commit, kind, offset, output ea, ptr0, ptr1);
endinterface

// ===== cis_alu.sv
`timescale 1ns/1ns
module cis_alu (
	// Operation and result
	cis_alu_if.alu p
);
	import cis_pkg::*;

	always_comb
	begin
		p.res  = p.a;
		p.cout = 1'b0;
		unique case (p.op)
			ALU_PASS: p.res = p.a;
			ALU_INV:  p.res = ~p.a; // RULE_08
			ALU_DEC:  p.res = p.a - 8'h01; // RULE_11
			ALU_INC:  p.res = p.a + 8'h01;
			ALU_OR:   p.res = p.a | p.b; // RULE_16
			ALU_SHL:  {p.cout, p.res} = {p.a, 1'b0}; // RULE_17
			ALU_SHR:  {p.res, p.cout} = {1'b0, p.a}; // RULE_18
			ALU_ZERO: p.res = 8'h00;
			ALU_BSET: p.res = p.a | (8'h01 << p.bsel); // RULE_03
			default:  p.res = p.a;
		endcase
	end

	assign p.zero    = (p.res == 8'h00);
	assign p.bit_val = p.a[p.bsel];

endmodule // cis_alu

// ===== cis_ptr.sv
`timescale 1ns/1ns
module cis_ptr (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	// Pointer requests
	cis_ptr_if.unit   p
);
	import cis_pkg::*;

	cis_ptr_t ptr_r [2];
	cis_ptr_t cur;
	cis_ptr_t stepped;

	assign cur    = p.sel ? ptr_r[1] : ptr_r[0];
	assign p.ptr0 = ptr_r[0];
	assign p.ptr1 = ptr_r[1];

	// Sixteen-bit sums wrap past either bound
	assign stepped = p.kind[0] ? cur - 16'h0001 : cur + 16'h0001; // RULE_23

	always_comb
	begin
		p.ea = cur;
		if (p.indexed)
			p.ea = cur + {{10{p.offset[OFS_MSB]}}, p.offset}; // RULE_21
		else
		begin
			unique case (p.kind) // RULE_20
				STEP_PRE_INC:  p.ea = stepped;
				STEP_PRE_DEC:  p.ea = stepped;
				STEP_POST_INC: p.ea = cur;
				STEP_POST_DEC: p.ea = cur;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			ptr_r[0] <= PTR_RESET;
			ptr_r[1] <= PTR_RESET;
		end
		else if (p.commit && !p.indexed)
		begin
			if (p.sel)
				ptr_r[1] <= stepped; // RULE_22
			else
				ptr_r[0] <= stepped; // RULE_22
		end
	end

endmodule // cis_ptr

// ===== cis_core.sv
`timescale 1ns/1ns
// Function
// RULE_01 - Relative jump adds signed nine-bit offset
// RULE_02 - Accumulator jump adds unsigned accumulator
// RULE_03 - Bit set forces selected bit, flags untouched
// RULE_04 - Bit one test skips next instruction
// RULE_05 - Literal call pushes return, loads literal
// RULE_06 - Accumulator call pushes, loads accumulator and latch
// RULE_07 - Watchdog kick clears counter, sets flags
// RULE_08 - Invert writes complement, updates zero
// RULE_09 - Register zeroing writes zero, sets zero
// RULE_10 - Accumulator zeroing clears it, sets zero
// RULE_11 - Decrement writes result, updates zero
// RULE_12 - Decrement skip on zero, flags untouched
// RULE_13 - Absolute jump loads literal, no push
// RULE_14 - Increment skip on zero, flags untouched
// RULE_15 - Literal OR into accumulator, zero updated
// RULE_16 - Register OR to destination, zero updated
// RULE_17 - Left shift, top bit to carry
// RULE_18 - Right shift, bottom bit to carry
// RULE_19 - Copy to destination, zero updated
// RULE_20 - Indirect load decodes four step kinds
// RULE_21 - Indexed load adds signed offset only
// RULE_22 - Pointer steps by one, byte loaded
// RULE_23 - Pointer wraps as sixteen-bit value
// RULE_24 - Window access redirects to pointer address
// RULE_25 - Skipped instruction has no side effects
module cis_core (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	// Program memory
	output cis_pkg::cis_pc_t      o_pm_addr,
	input  wire  cis_pkg::cis_op_t i_pm_data,
	// Upper program counter latch
	input  wire logic [6:0]       i_pc_upper_latch,
	// File register data space
	output cis_pkg::cis_ptr_t     o_dm_addr,
	output logic                  o_dm_re,
	output logic                  o_dm_we,
	output logic [7:0]            o_dm_wdata,
	input  wire logic [7:0]       i_dm_rdata,
	// Core state
	output logic [7:0]            o_w,
	output logic                  o_zero_flag,
	output logic                  o_carry_flag,
	output logic                  o_timeout_flag,
	output logic                  o_sleep_entry_flag,
	output logic                  o_watchdog_clear,
	output cis_pkg::cis_pc_t      o_return_stack_head,
	output logic                  o_discard
);
	import cis_pkg::*;

	cis_alu_if alu_bus ();
	cis_ptr_if ptr_bus ();

	cis_alu u_alu (
		.p (alu_bus)
	);

	cis_ptr u_ptr (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.p       (ptr_bus)
	);

	cis_pc_t    pc_r;
	cis_pc_t    pc_nxt;
	cis_pc_t    pc_inc;
	logic [7:0] w_r;
	logic       z_r;
	logic       c_r;
	logic       to_r;
	logic       pd_r;
	logic       kick_r;
	logic       hold_r;
	logic       skip_r;
	logic       hold_nxt;
	logic       skip_nxt;
	cis_pc_t    stack_r [STACK_DEPTH];
	logic [3:0] sp_r;
	cis_pc_t    tos_r;

	cis_op_t    op;
	logic [6:0] f_addr;
	logic       dest_f;
	logic       discard;
	logic       lit_a;
	logic       rd_f;
	logic       wr_w;
	logic       wr_f;
	logic       upd_z;
	logic       upd_c;
	logic       push;
	logic       kick;
	logic       ptr_use;

	assign op      = i_pm_data;
	assign f_addr  = op[F_MSB:0];
	assign dest_f  = op[DEST_BIT];
	assign pc_inc  = pc_r + 15'h0001;
	assign discard = hold_r | skip_r;

	// Instruction decode
	always_comb
	begin
		alu_bus.op      = ALU_PASS;
		alu_bus.b       = w_r;
		alu_bus.bsel    = op[BIT_MSB:BIT_LSB];
		lit_a           = 1'b0;
		rd_f            = 1'b0;
		wr_w            = 1'b0;
		wr_f            = 1'b0;
		upd_z           = 1'b0;
		upd_c           = 1'b0;
		push            = 1'b0;
		kick            = 1'b0;
		ptr_use         = 1'b0;
		ptr_bus.sel     = op[SEL_STEP];
		ptr_bus.indexed = 1'b0;
		ptr_bus.kind    = op[1:0];
		ptr_bus.offset  = op[OFS_MSB:0];
		hold_nxt        = 1'b0;
		skip_nxt        = 1'b0;
		pc_nxt          = pc_inc;
		if (discard)
		begin
			// A discarded slot holds the counter after a jump and only lets it move on after a skip
			pc_nxt = hold_r ? pc_r : pc_inc; // RULE_25
		end
		else if (is_op(op, M_ACCUMULATOR_ZEROING, V_ACCUMULATOR_ZEROING))
		begin
			alu_bus.op = ALU_ZERO; // RULE_10
			wr_w       = 1'b1;
			upd_z      = 1'b1;
		end
		else if (is_op(op, M_REGISTER_ZEROING, V_REGISTER_ZEROING))
		begin
			alu_bus.op = ALU_ZERO; // RULE_09
			wr_f       = 1'b1;
			upd_z      = 1'b1;
		end
		else if (is_op(op, M_BIT, V_BSET))
		begin
			alu_bus.op = ALU_BSET; // RULE_03
			rd_f       = 1'b1;
			wr_f       = 1'b1;
		end
		else if (is_op(op, M_BIT, V_BTST))
		begin
			rd_f     = 1'b1;
			skip_nxt = alu_bus.bit_val; // RULE_04
		end
		else if (is_op(op, M_BYTE, V_INV))
		begin
			alu_bus.op = ALU_INV; // RULE_08
			rd_f       = 1'b1;
			wr_f       = dest_f;
			wr_w       = !dest_f;
			upd_z      = 1'b1;
		end
		else if (is_op(op, M_BYTE, V_DEC) || is_op(op, M_BYTE, V_INC))
		begin
			alu_bus.op = is_op(op, M_BYTE, V_INC) ? ALU_INC : ALU_DEC; // RULE_11
			rd_f       = 1'b1;
			wr_f       = dest_f;
			wr_w       = !dest_f;
			upd_z      = 1'b1;
		end
		else if (is_op(op, M_BYTE, V_DECSZ) || is_op(op, M_BYTE, V_INCSZ))
		begin
			alu_bus.op = is_op(op, M_BYTE, V_INCSZ) ? ALU_INC : ALU_DEC; // RULE_12 RULE_14
			rd_f       = 1'b1;
			wr_f       = dest_f;
			wr_w       = !dest_f;
			skip_nxt   = alu_bus.zero; // RULE_12 RULE_14
		end
		else if (is_op(op, M_BYTE, V_ORF))
		begin
			alu_bus.op = ALU_OR; // RULE_16
			rd_f       = 1'b1;
			wr_f       = dest_f;
			wr_w       = !dest_f;
			upd_z      = 1'b1;
		end
		else if (is_op(op, M_BYTE, V_COPY))
		begin
			alu_bus.op = ALU_PASS; // RULE_19
			rd_f       = 1'b1;
			wr_f       = dest_f;
			wr_w       = !dest_f;
			upd_z      = 1'b1;
		end
		else if (is_op(op, M_BYTE, V_SHL) || is_op(op, M_BYTE, V_SHR))
		begin
			alu_bus.op = op[DEST_BIT + 2] ? ALU_SHR : ALU_SHL; // RULE_17 RULE_18
			rd_f       = 1'b1;
			wr_f       = dest_f;
			wr_w       = !dest_f;
			upd_z      = 1'b1;
			upd_c      = 1'b1;
		end
		else if (is_op(op, M_BYTE, V_ORL))
		begin
			alu_bus.op = ALU_OR; // RULE_15
			lit_a      = 1'b1;
			wr_w       = 1'b1;
			upd_z      = 1'b1;
		end
		else if (is_op(op, M_BRA, V_BRA))
		begin
			pc_nxt   = pc_inc + {{6{op[BRA_MSB]}}, op[BRA_MSB:0]}; // RULE_01
			hold_nxt = 1'b1;
		end
		else if (is_op(op, M_EXACT, V_BRW))
		begin
			pc_nxt   = pc_inc + {7'h00, w_r}; // RULE_02
			hold_nxt = 1'b1;
		end
		else if (is_op(op, M_JMP, V_CALL) || is_op(op, M_JMP, V_ABSOLUTE_JUMP))
		begin
			pc_nxt   = {i_pc_upper_latch[6:3], op[JMP_MSB:0]}; // RULE_05 RULE_13
			push     = !op[JMP_MSB + 1]; // RULE_05
			hold_nxt = 1'b1;
		end
		else if (is_op(op, M_EXACT, V_ACCUMULATOR_SUBROUTINE_ENTER))
		begin
			pc_nxt   = {i_pc_upper_latch, w_r}; // RULE_06
			push     = 1'b1;
			hold_nxt = 1'b1;
		end
		else if (is_op(op, M_EXACT, V_KICK))
		begin
			kick = 1'b1; // RULE_07
		end
		else if (is_op(op, M_ILDS, V_ILDS) || is_op(op, M_ILDX, V_ILDX))
		begin
			ptr_use         = 1'b1; // RULE_20
			ptr_bus.indexed = op[13]; // RULE_21
			ptr_bus.sel     = op[13] ? op[SEL_IDX] : op[SEL_STEP];
			alu_bus.op      = ALU_PASS; // RULE_22
			wr_w            = 1'b1;
			upd_z           = 1'b1;
		end
	end

	assign alu_bus.a      = lit_a ? op[LIT8_MSB:0] : i_dm_rdata;
	assign ptr_bus.commit = ptr_use;

	// Data space address, windows redirected through the pointers
	always_comb
	begin
		o_dm_addr = {9'h000, f_addr};
		if (ptr_use)
			o_dm_addr = ptr_bus.ea; // RULE_20
		else if (f_addr == WINDOW0_ADDR)
			o_dm_addr = ptr_bus.ptr0; // RULE_24
		else if (f_addr == WINDOW1_ADDR)
			o_dm_addr = ptr_bus.ptr1; // RULE_24
	end

	assign o_dm_re    = rd_f | ptr_use;
	assign o_dm_we    = wr_f;
	assign o_dm_wdata = alu_bus.res;

	// Program flow
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pc_r   <= PC_RESET;
			hold_r <= FLAG_RESET;
			skip_r <= FLAG_RESET;
		end
		else
		begin
			pc_r   <= pc_nxt;
			hold_r <= hold_nxt; // RULE_01 RULE_13
			skip_r <= skip_nxt; // RULE_04
		end
	end

	// Accumulator
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			w_r <= W_RESET;
		else if (wr_w)
			w_r <= alu_bus.res;
	end

	// Status flags
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			z_r <= FLAG_RESET;
			c_r <= FLAG_RESET;
		end
		else
		begin
			if (upd_z)
				z_r <= alu_bus.zero;
			if (upd_c)
				c_r <= alu_bus.cout;
		end
	end

	// Return stack, wraps when full
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			sp_r  <= SP_RESET;
			tos_r <= PC_RESET;
		end
		else if (push)
		begin
			sp_r  <= sp_r + 4'h1; // RULE_05 RULE_06
			tos_r <= pc_inc;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (push)
			stack_r[sp_r] <= pc_inc; // RULE_05 RULE_06
	end

	// Watchdog kick
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			to_r   <= TO_RESET;
			pd_r   <= PD_RESET;
			kick_r <= FLAG_RESET;
		end
		else
		begin
			kick_r <= kick; // RULE_07
			if (kick)
			begin
				to_r <= 1'b1; // RULE_07
				pd_r <= 1'b1;
			end
		end
	end

	assign o_pm_addr           = pc_r;
	assign o_w                 = w_r;
	assign o_zero_flag         = z_r;
	assign o_carry_flag        = c_r;
	assign o_timeout_flag      = to_r;
	assign o_sleep_entry_flag  = pd_r;
	assign o_watchdog_clear    = kick_r;
	assign o_return_stack_head = tos_r;
	assign o_discard           = discard;

endmodule // cis_core

// ===== cis_core_assertions.sv
`timescale 1ns/1ns
module cis_core_assertions (
	// Clock and reset
	input wire logic             i_clk,
	input wire logic             i_reset,
	// Program side
	input wire cis_pkg::cis_pc_t o_pm_addr,
	input wire cis_pkg::cis_op_t i_pm_data,
	input wire logic [6:0]       i_pc_upper_latch,
	// Core state
	input wire logic             o_dm_we,
	input wire logic [7:0]       o_w,
	input wire logic             o_zero_flag,
	input wire logic             o_carry_flag,
	input wire logic             o_timeout_flag,
	input wire logic             o_sleep_entry_flag,
	input wire logic             o_watchdog_clear,
	input wire cis_pkg::cis_pc_t o_return_stack_head,
	input wire logic             o_discard
);
	import cis_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire ex = !o_discard;

	a_bra_target: assert property ((ex && (i_pm_data & M_BRA) == V_BRA) |=> o_discard &&
		o_pm_addr == $past(o_pm_addr) + 15'h0001
		+ {{6{$past(i_pm_data[8])}}, $past(i_pm_data[8:0])}) else $error("relative jump target");
	a_brw_target: assert property ((ex && i_pm_data == V_BRW) |=> o_discard &&
		o_pm_addr == $past(o_pm_addr) + 15'h0001 + {7'h00, $past(o_w)}) else $error("w jump target");
	a_call_push: assert property ((ex && (i_pm_data & M_JMP) == V_CALL) |=>
		o_return_stack_head == $past(o_pm_addr) + 15'h0001
		&& o_pm_addr == {$past(i_pc_upper_latch[6:3]), $past(i_pm_data[10:0])})
		else $error("call push or target");
	a_accumulator_subroutine_enter_load: assert property ((ex && i_pm_data == V_ACCUMULATOR_SUBROUTINE_ENTER) |=>
		o_return_stack_head == $past(o_pm_addr) + 15'h0001
		&& o_pm_addr == {$past(i_pc_upper_latch), $past(o_w)}) else $error("w call target");
	a_absolute_jump_target: assert property ((ex && (i_pm_data & M_JMP) == V_ABSOLUTE_JUMP) |=>
		$stable(o_return_stack_head) && o_discard
		&& o_pm_addr == {$past(i_pc_upper_latch[6:3]), $past(i_pm_data[10:0])})
		else $error("jump target");
	a_kick_flags: assert property ((ex && i_pm_data == V_KICK) |=>
		o_watchdog_clear && o_timeout_flag && o_sleep_entry_flag) else $error("kick");
	a_accumulator_zeroing_zero: assert property ((ex && (i_pm_data & M_ACCUMULATOR_ZEROING) == V_ACCUMULATOR_ZEROING) |=>
		o_w == 8'h00 && o_zero_flag) else $error("accumulator clear");
	a_orl_result: assert property ((ex && (i_pm_data & M_BYTE) == V_ORL) |=>
		o_w == ($past(o_w) | $past(i_pm_data[7:0])) && o_zero_flag == (o_w == 8'h00)
		&& $stable(o_carry_flag)) else $error("or literal");
	a_bubble_once: assert property (o_discard |=> !o_discard) else $error("long bubble");
	a_discard_quiet: assert property (o_discard |-> !o_dm_we ##1
		($stable(o_w) && $stable(o_zero_flag) && $stable(o_carry_flag))) else $error("discard act");
endmodule // cis_core_assertions

bind cis_core cis_core_assertions u_chk (
	.i_clk              (i_clk),
	.i_reset            (i_reset),
	.o_pm_addr          (o_pm_addr),
	.i_pm_data          (i_pm_data),
	.i_pc_upper_latch   (i_pc_upper_latch),
	.o_dm_we            (o_dm_we),
	.o_w                (o_w),
	.o_zero_flag        (o_zero_flag),
	.o_carry_flag       (o_carry_flag),
	.o_timeout_flag     (o_timeout_flag),
	.o_sleep_entry_flag (o_sleep_entry_flag),
	.o_watchdog_clear   (o_watchdog_clear),
	.o_return_stack_head(o_return_stack_head),
	.o_discard          (o_discard)
);

// ===== cis_mem.sv
`timescale 1ns/1ns
module cis_mem (
	// Clock
	input  wire logic              i_clk,
	// Program memory
	input  wire cis_pkg::cis_pc_t  i_pm_addr,
	output cis_pkg::cis_op_t       o_pm_data,
	// Data space
	input  wire cis_pkg::cis_ptr_t i_dm_addr,
	input  wire logic              i_dm_re,
	input  wire logic              i_dm_we,
	input  wire logic [7:0]        i_dm_wdata,
	output logic [7:0]             o_dm_rdata
);
	import cis_pkg::*;
	cis_op_t    rom [0:4095];
	logic [7:0] ram [0:255];

	initial
	begin
		for (int i = 0; i < 4096; i++)
			rom[i] = 14'h0000;
		for (int i = 0; i < 256; i++)
			ram[i] = 8'h00;
	end

	// Data space aliases every 256 bytes
	assign o_pm_data = rom[i_pm_addr[11:0]];
	// Unselected reads return the inverse so a stray sample is caught
	assign o_dm_rdata = i_dm_re ? ram[i_dm_addr[7:0]] : ~ram[i_dm_addr[7:0]];

	always @(posedge i_clk)
		if (i_dm_we)
			ram[i_dm_addr[7:0]] <= i_dm_wdata;
endmodule // cis_mem

// ===== cis_core_tb.sv
`timescale 1ns/1ns
module cis_core_tb;
	import cis_pkg::*;
	logic       i_clk   = 1'b0;
	logic       i_reset = 1'b1;
	logic [6:0] latch   = 7'h0A;
	cis_pc_t    pm_addr;
	cis_pc_t    head;
	cis_op_t    pm_data;
	cis_ptr_t   dm_addr;
	logic       dm_re, dm_we, zf, cf, tof, pdf, wdc, disc;
	logic [7:0] dm_wdata, dm_rdata, w_q;
	int         mismatches  = 0;
	int         check_count = 0;

	always #50 i_clk = ~i_clk;

	cis_core u_dut (
		.i_clk(i_clk), .i_reset(i_reset), .o_pm_addr(pm_addr), .i_pm_data(pm_data),
		.i_pc_upper_latch(latch), .o_dm_addr(dm_addr), .o_dm_re(dm_re), .o_dm_we(dm_we),
		.o_dm_wdata(dm_wdata), .i_dm_rdata(dm_rdata), .o_w(w_q), .o_zero_flag(zf),
		.o_carry_flag(cf), .o_timeout_flag(tof), .o_sleep_entry_flag(pdf),
		.o_watchdog_clear(wdc), .o_return_stack_head(head), .o_discard(disc)
	);

	cis_mem u_mem (
		.i_clk(i_clk), .i_pm_addr(pm_addr), .o_pm_data(pm_data), .i_dm_addr(dm_addr),
		.i_dm_re(dm_re), .i_dm_we(dm_we), .i_dm_wdata(dm_wdata), .o_dm_rdata(dm_rdata)
	);

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task end_sim;
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Place op at the current pc, run one cycle, check pc, W and {Z,C,discard}
	task automatic x(input cis_op_t op, input logic [15:0] pc, input logic [7:0] w,
		input logic [2:0] f, input logic [15:0] ea = 16'h0000);
		u_mem.rom[pm_addr[11:0]] = op;
		#1;
		if (ea != 16'h0000)
			cmp(dm_addr, ea);
		@(posedge i_clk);
		@(negedge i_clk);
		cmp({1'b0, pm_addr}, pc);
		cmp({8'h00, w_q}, {8'h00, w});
		cmp({13'h0000, zf, cf, disc}, {13'h0000, f});
	endtask

	initial
	begin
		repeat (2000) @(posedge i_clk);
		mismatches++;
		end_sim;
	end

	initial
	begin
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		@(negedge i_clk);
		u_mem.ram[8'h20] = 8'h81;
		u_mem.ram[8'h21] = 8'hAA;
		u_mem.ram[8'h22] = 8'hFF;
		u_mem.ram[8'h24] = 8'h01;
		u_mem.ram[8'h25] = 8'hFF;
		u_mem.ram[8'h02] = 8'h99;
		u_mem.ram[8'hFF] = 8'h3C;
		x(14'h385A, 16'h0001, 8'h5A, 3'b000);
		x(14'h0920, 16'h0002, 8'h7E, 3'b000);
		x(14'h09A0, 16'h0003, 8'h7E, 3'b000);
		x(14'h0100, 16'h0004, 8'h00, 3'b100);
		x(14'h0420, 16'h0005, 8'h7E, 3'b000);
		x(14'h01A1, 16'h0006, 8'h7E, 3'b100);
		x(14'h0321, 16'h0007, 8'hFF, 3'b000);
		x(14'h03A2, 16'h0008, 8'hFF, 3'b000);
		x(14'h3522, 16'h0009, 8'hFC, 3'b010);
		x(14'h3624, 16'h000A, 8'h00, 3'b110);
		x(14'h08A0, 16'h000B, 8'h00, 3'b010);
		x(14'h15A1, 16'h000C, 8'h00, 3'b010);
		x(14'h0F22, 16'h000D, 8'hFF, 3'b010);
		x(14'h0FA5, 16'h000E, 8'hFF, 3'b011);
		x(14'h0100, 16'h000F, 8'hFF, 3'b010);
		x(14'h0B24, 16'h0010, 8'h00, 3'b011);
		x(14'h38FF, 16'h0011, 8'h00, 3'b010);
		x(14'h1DA1, 16'h0012, 8'h00, 3'b011);
		x(14'h01A0, 16'h0013, 8'h00, 3'b010);
		x(14'h1D21, 16'h0014, 8'h00, 3'b010);
		x(14'h3803, 16'h0015, 8'h03, 3'b010);
		x(14'h000B, 16'h0019, 8'h03, 3'b011);
		x(14'h0100, 16'h0019, 8'h03, 3'b010);
		x(14'h33FE, 16'h0018, 8'h03, 3'b011);
		x(14'h0000, 16'h0018, 8'h03, 3'b010);
		x(14'h3214, 16'h002D, 8'h03, 3'b011);
		x(14'h0000, 16'h002D, 8'h03, 3'b010);
		x(14'h2100, 16'h0900, 8'h03, 3'b011);
		cmp({1'b0, head}, 16'h002E);
		x(14'h0000, 16'h0900, 8'h03, 3'b010);
		x(14'h3810, 16'h0901, 8'h13, 3'b010);
		x(14'h000A, 16'h0A13, 8'h13, 3'b011);
		x(14'h0000, 16'h0A13, 8'h13, 3'b010);
		cmp({1'b0, head}, 16'h0902);
		x(14'h0064, 16'h0A14, 8'h13, 3'b010);
		cmp({13'h0000, wdc, tof, pdf}, 16'h0007);
		// New upper latch so the upper four counter bits move on the absolute jump
		latch <= 7'h35;
		x(14'h2850, 16'h3050, 8'h13, 3'b011);
		cmp({15'h0000, wdc}, 16'h0000);
		x(14'h0000, 16'h3050, 8'h13, 3'b010);
		cmp({1'b0, head}, 16'h0902);
		x(14'h0011, 16'h3051, 8'h3C, 3'b010, 16'hFFFF);
		x(14'h0012, 16'h3052, 8'h3C, 3'b010, 16'hFFFF);
		x(14'h0010, 16'h3053, 8'h00, 3'b110, 16'h0001);
		x(14'h0012, 16'h3054, 8'h00, 3'b110, 16'h0001);
		x(14'h0013, 16'h3055, 8'h99, 3'b010, 16'h0002);
		x(14'h3F7F, 16'h3056, 8'h3C, 3'b010, 16'hFFFF);
		x(14'h3F42, 16'h3057, 8'h99, 3'b010, 16'h0002);
		x(14'h3F42, 16'h3058, 8'h99, 3'b010, 16'h0002);
		x(14'h0800, 16'h3059, 8'h00, 3'b110, 16'h0001);
		x(14'h0A23, 16'h305A, 8'h01, 3'b010);
		cmp({8'h00, u_mem.ram[8'h20]}, 16'h007E);
		cmp({8'h00, u_mem.ram[8'h21]}, 16'h0008);
		cmp({8'h00, u_mem.ram[8'h22]}, 16'h00FE);
		cmp({8'h00, u_mem.ram[8'h24]}, 16'h0001);
		cmp({8'h00, u_mem.ram[8'h25]}, 16'h0000);
		end_sim;
	end
endmodule // cis_core_tb
